//--- pkg/pors_pkg.sv
// Package: constants and types for the power-on reset sequencer
package pors_pkg;
    // ------------------------------------------------------------
    // Timing (printed figures in ns, counts at 50 MHz)
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned T_EXT_FIRST_LVD_NS = 832000;
    localparam int unsigned T_EXT_FIRST_NOLVD_NS = 519000;
    localparam int unsigned T_EXT_LATER_LVD_NS = 675000;
    localparam int unsigned T_EXT_LATER_NOLVD_NS = 362000;
    localparam int unsigned T_LVD_MAX_NS = 70100;
    localparam int unsigned T_LVD_TYP_NS = 51100;
    // Longest times round down
    localparam int unsigned CYC_EXT_FIRST_LVD =
        T_EXT_FIRST_LVD_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_EXT_FIRST_NOLVD =
        T_EXT_FIRST_NOLVD_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_EXT_LATER_LVD =
        T_EXT_LATER_LVD_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_EXT_LATER_NOLVD =
        T_EXT_LATER_NOLVD_NS / CLK_PERIOD_NS;
    localparam int unsigned CYC_LVD_TYP = T_LVD_TYP_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 16;
    // ------------------------------------------------------------
    // Register map (word byte addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_CAUSE = 6'h00;
    localparam logic [5:0] ADDR_LVDCTL = 6'h04;
    localparam logic [5:0] ADDR_STAT = 6'h08;
    localparam logic [5:0] ADDR_IRQ_ST = 6'h0C;
    localparam logic [5:0] ADDR_IRQ_EN = 6'h10;
    // IRQ_CLR is one word above IRQ_EN
    localparam logic [5:0] ADDR_IRQ_CLR = 6'h14;
    // Cause flag bit positions
    localparam int unsigned CF_LVD = 0;
    localparam int unsigned CF_ILLMEM = 1;
    localparam int unsigned CF_PARITY = 2;
    localparam int unsigned CF_WDT = 4;
    localparam int unsigned CF_SYSREQ = 7;
    localparam logic [7:0] CAUSE_RST = 8'h00;
    localparam int unsigned N_IRQ = 3;
    // Monitor mode option codes
    localparam logic [1:0] MODE_INT_RST = 2'h2;
    localparam logic [1:0] MODE_RST = 2'h3;
    localparam logic [1:0] MODE_INT = 2'h1;
    localparam logic [1:0] MODE_OFF = 2'h0;
    // Internal reset event sources
    typedef struct packed {
        logic sysreq;
        logic wdt;
        logic parity;
        logic illmem;
    } pors_rst_src_t;
    // Supply comparator outcomes
    typedef struct packed {
        logic above_rise;
        logic below_fall;
        logic mon_above_high;
        logic mon_below_low;
    } pors_cmp_t;
    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_EXTHOLD = 3'h1,
        ST_PROC = 3'h2,
        ST_RUN = 3'h3,
        ST_LVDHOLD = 3'h4
    } pors_state_t;
endpackage : pors_pkg

//--- src/pors_timer.sv
// Module: reset processing interval counter
`timescale 1ns/1ps
module pors_timer #(
    parameter int unsigned W = 16
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic start_in,
    input wire logic [W-1:0] load_in,
    output logic done_out,
    output logic busy_out
);
    logic [W-1:0] cnt_r;
    // ------------------------------------------------------------
    // Down counter; load of zero finishes next cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_r <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else if (start_in) begin
            cnt_r <= load_in;
            busy_out <= 1'b1;
            done_out <= 1'b0;
        end else if (busy_out) begin
            if (cnt_r == '0) begin
                busy_out <= 1'b0;
                done_out <= 1'b1; // One-cycle pulse
            end else begin
                cnt_r <= cnt_r - W'(1);
                done_out <= 1'b0;
            end
        end else begin
            done_out <= 1'b0;
        end
    end
endmodule : pors_timer

//--- src/pors_avs.sv
// Module: Avalon-MM slave handshake with one wait state
`timescale 1ns/1ps
module pors_avs (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic read_in,
    input wire logic write_in,
    output logic waitrequest_out,
    output logic strobe_out
);
    logic wait_r;
    // ------------------------------------------------------------
    // Each access waits one cycle, then completes
    // ------------------------------------------------------------
    // Kept as the flop itself so the bus output has no logic after it
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~((read_in | write_in) & wait_r);
        end
    end
    assign waitrequest_out = wait_r;
    // Access takes effect on the edge where waitrequest is low
    assign strobe_out = ~wait_r & (read_in | write_in);
endmodule : pors_avs

//--- src/pors_top.sv
// Module: power-on reset sequencer top
// Contract
// - Hold reset until supply rises past threshold
// - Below falling threshold, reset stays asserted
// - Power-on reset clears all cause flags
// - Other internal resets set their cause flag
// - First external release: 0.832/0.519 ms processing
// - Later external releases: 0.675/0.362 ms processing
// - Processing includes oscillator accuracy wait
// - Drop interrupt sets level and mode bits
// - Power-up monitor processing up to 0.0701 ms
// - Monitor reset recovery takes 0.0511 ms typical
// - Interrupt-only mode uses reset-mode timing
// - After processing, run from internal oscillator
`timescale 1ns/1ps
module pors_top #(
    parameter int unsigned CYC_FIRST_LVD = pors_pkg::CYC_EXT_FIRST_LVD,
    parameter int unsigned CYC_FIRST_NOLVD = pors_pkg::CYC_EXT_FIRST_NOLVD,
    parameter int unsigned CYC_LATER_LVD = pors_pkg::CYC_EXT_LATER_LVD,
    parameter int unsigned CYC_LATER_NOLVD = pors_pkg::CYC_EXT_LATER_NOLVD,
    parameter int unsigned CYC_LVD = pors_pkg::CYC_LVD_TYP
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire pors_pkg::pors_cmp_t cmp_in,
    input wire logic ext_reset_n_in,
    input wire pors_pkg::pors_rst_src_t src_in,
    input wire logic [1:0] monitor_mode_option_in,
    input wire logic voltage_drop_event_in,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic int_reset_out,
    output logic cpu_clk_en_out,
    output logic hoco_sel_out,
    output logic voltage_drop_interrupt_out,
    output logic irq_out
);
    localparam int unsigned W = pors_pkg::CNT_W;
    pors_pkg::pors_state_t state_r;
    pors_pkg::pors_state_t state_nxt;
    logic [7:0] reset_cause_flags_r;
    logic detect_level_select_r;
    logic detect_mode_select_r;
    logic first_ext_r;
    logic [pors_pkg::N_IRQ-1:0] irq_st_r;
    logic [pors_pkg::N_IRQ-1:0] irq_en_r;
    logic ext_ok;
    logic lvd_on;
    logic lvd_low;
    logic por_low;
    logic any_src;
    logic start;
    logic [W-1:0] load;
    logic done;
    logic busy;
    logic strobe;
    logic wr;
    logic [pors_pkg::N_IRQ-1:0] ev;
    // ------------------------------------------------------------
    // Supply conditions
    // ------------------------------------------------------------
    assign lvd_on = monitor_mode_option_in != pors_pkg::MODE_OFF;
    // Interrupt-only mode still holds reset until level is reached
    assign lvd_low = lvd_on & cmp_in.mon_below_low;
    // Above the power-on threshold, the external pin is the only guard when the monitor is off
    assign ext_ok = ext_reset_n_in;
    assign por_low = cmp_in.below_fall | ~cmp_in.above_rise;
    assign any_src = |src_in;
    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        start = 1'b0;
        load = '0;
        unique case (state_r)
            pors_pkg::ST_POR: begin
                if (!por_low) begin
                    state_nxt = lvd_low ? pors_pkg::ST_LVDHOLD
                                        : pors_pkg::ST_EXTHOLD;
                end
            end
            pors_pkg::ST_LVDHOLD: begin
                if (!lvd_low) begin
                    state_nxt = pors_pkg::ST_EXTHOLD;
                end
            end
            pors_pkg::ST_EXTHOLD: begin
                if (ext_ok) begin
                    state_nxt = pors_pkg::ST_PROC;
                    start = 1'b1;
                    if (first_ext_r) begin
                        load = lvd_on ? W'(CYC_FIRST_LVD)
                                      : W'(CYC_FIRST_NOLVD);
                    end else begin
                        load = lvd_on ? W'(CYC_LATER_LVD)
                                      : W'(CYC_LATER_NOLVD);
                    end
                    // Monitor interval added after its level is met
                    if (lvd_on) begin
                        load = load + W'(CYC_LVD);
                    end
                end
            end
            pors_pkg::ST_PROC: begin
                // Interval covers the oscillator accuracy wait
                if (done) begin
                    state_nxt = pors_pkg::ST_RUN;
                end
            end
            pors_pkg::ST_RUN: begin
                if (!ext_ok || any_src) begin
                    state_nxt = pors_pkg::ST_EXTHOLD;
                end
            end
            default: state_nxt = pors_pkg::ST_POR;
        endcase
        // Supply faults override every state
        if (por_low) begin
            state_nxt = pors_pkg::ST_POR;
            start = 1'b0;
        end else if (lvd_low && state_r != pors_pkg::ST_POR) begin
            state_nxt = pors_pkg::ST_LVDHOLD;
            start = 1'b0;
        end
    end
    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r <= pors_pkg::ST_POR;
        end else begin
            state_r <= state_nxt;
        end
    end
    // ------------------------------------------------------------
    // First release after power-on tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in || state_r == pors_pkg::ST_POR) begin
            first_ext_r <= 1'b1;
        end else if (start) begin
            first_ext_r <= 1'b0;
        end
    end
    pors_timer #(
        .W(W)
    ) u_timer (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .start_in(start),
        .load_in(load),
        .done_out(done),
        .busy_out(busy)
    );
    // ------------------------------------------------------------
    // Reset and clock outputs; CPU clock gated until counter ends
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            int_reset_out <= 1'b1;
            cpu_clk_en_out <= 1'b0;
            hoco_sel_out <= 1'b1;
        end else begin
            int_reset_out <= state_nxt != pors_pkg::ST_RUN;
            cpu_clk_en_out <= state_nxt == pors_pkg::ST_RUN;
            // Always start on internal oscillator; crystal is software
            hoco_sel_out <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in || state_r == pors_pkg::ST_POR) begin
            reset_cause_flags_r <= pors_pkg::CAUSE_RST;
        end else begin
            if (state_r == pors_pkg::ST_RUN && src_in.sysreq) begin
                reset_cause_flags_r[pors_pkg::CF_SYSREQ] <= 1'b1;
            end
            if (state_r == pors_pkg::ST_RUN && src_in.wdt) begin
                reset_cause_flags_r[pors_pkg::CF_WDT] <= 1'b1;
            end
            if (state_r == pors_pkg::ST_RUN && src_in.parity) begin
                reset_cause_flags_r[pors_pkg::CF_PARITY] <= 1'b1;
            end
            if (state_r == pors_pkg::ST_RUN && src_in.illmem) begin
                reset_cause_flags_r[pors_pkg::CF_ILLMEM] <= 1'b1;
            end
            if (state_nxt == pors_pkg::ST_LVDHOLD &&
                state_r != pors_pkg::ST_LVDHOLD) begin
                reset_cause_flags_r[pors_pkg::CF_LVD] <= 1'b1;
            end
        end
    end
    // ------------------------------------------------------------
    // Level and mode select bits; set by drop interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in || state_r == pors_pkg::ST_POR) begin
            detect_level_select_r <= 1'b0;
            detect_mode_select_r <= 1'b0;
            voltage_drop_interrupt_out <= 1'b0;
        end else begin
            voltage_drop_interrupt_out <= voltage_drop_event_in &&
                monitor_mode_option_in == pors_pkg::MODE_INT_RST &&
                state_r == pors_pkg::ST_RUN;
            if (voltage_drop_interrupt_out) begin
                detect_level_select_r <= 1'b1;
                detect_mode_select_r <= 1'b1;
            end else if (wr && avs_address_in ==
                         pors_pkg::ADDR_LVDCTL &&
                         monitor_mode_option_in ==
                         pors_pkg::MODE_INT_RST) begin
                // Software may only write in interrupt-and-reset mode
                detect_level_select_r <= avs_writedata_in[0];
                detect_mode_select_r <= avs_writedata_in[7];
            end
        end
    end
    // ------------------------------------------------------------
    // Interrupt status, enable, clear; set beats clear
    // ------------------------------------------------------------
    assign ev = {done, voltage_drop_interrupt_out,
                 state_r == pors_pkg::ST_RUN && any_src};
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_st_r <= '0;
            irq_en_r <= '0;
            irq_out <= 1'b0;
        end else begin
            if (wr && avs_address_in == pors_pkg::ADDR_IRQ_CLR) begin
                irq_st_r <= (irq_st_r &
                    ~avs_writedata_in[pors_pkg::N_IRQ-1:0]) | ev;
            end else begin
                irq_st_r <= irq_st_r | ev;
            end
            if (wr && avs_address_in == pors_pkg::ADDR_IRQ_EN) begin
                irq_en_r <= avs_writedata_in[pors_pkg::N_IRQ-1:0];
            end
            irq_out <= |(irq_st_r & irq_en_r);
        end
    end
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    pors_avs u_avs (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .read_in(avs_read_in),
        .write_in(avs_write_in),
        .waitrequest_out(avs_waitrequest_out),
        .strobe_out(strobe)
    );
    assign wr = strobe & avs_write_in;
    // Read data prepared during the wait cycle; unmapped reads zero
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            avs_readdata_out <= 32'h0;
        end else begin
            unique case (avs_address_in)
                6'h00: avs_readdata_out <= {24'h0, reset_cause_flags_r};
                6'h04: avs_readdata_out <= {24'h0, detect_mode_select_r,
                                            6'h00, detect_level_select_r};
                6'h08: avs_readdata_out <= {28'h0, busy, state_r};
                6'h0C: avs_readdata_out <= {29'h0, irq_st_r};
                6'h10: avs_readdata_out <= {29'h0, irq_en_r};
                default: avs_readdata_out <= 32'h0;
            endcase
        end
    end
endmodule : pors_top

//--- sim/pors_top_monitor.sv
// Checker: port-level assertions for the reset sequencer
`timescale 1ns/1ps
module pors_top_monitor #(
    parameter int unsigned CYC_FIRST_LVD = 20,
    parameter int unsigned CYC_LATER_NOLVD = 8,
    parameter int unsigned CYC_LVD = 5
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire pors_pkg::pors_cmp_t cmp_in,
    input wire logic ext_reset_n_in,
    input wire pors_pkg::pors_rst_src_t src_in,
    input wire logic [1:0] monitor_mode_option_in,
    input wire logic voltage_drop_event_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic int_reset_out,
    input wire logic cpu_clk_en_out,
    input wire logic hoco_sel_out,
    input wire logic voltage_drop_interrupt_out
);
    // Slack covers state and output register stages
    localparam int PROC_MAX = CYC_FIRST_LVD + CYC_LVD + 6;
    logic supply_bad;
    logic [15:0] wait_r;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // Any supply condition that must keep the chip in reset
    assign supply_bad = !cmp_in.above_rise || cmp_in.below_fall ||
        (monitor_mode_option_in != 2'h0 && cmp_in.mon_below_low);
    // Cycles spent in reset while every release condition is met
    always_ff @(posedge clk_in) begin
        if (srst_in || !int_reset_out || !ext_reset_n_in || supply_bad) begin
            wait_r <= 16'h0000;
        end else begin
            wait_r <= wait_r + 16'h0001;
        end
    end
    sequence s_req_start;
        $rose(avs_read_in || avs_write_in);
    endsequence
    sequence s_one_wait;
        avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence
    chk_rise_gate: assert property ((!cmp_in.above_rise) [*3] |->
        int_reset_out)
        else $error("reset released below rising threshold");
    chk_fall_hold: assert property (cmp_in.below_fall [*3] |->
        int_reset_out)
        else $error("reset released below falling threshold");
    chk_ext_hold: assert property ((!ext_reset_n_in) [*3] |->
        int_reset_out)
        else $error("reset released while external reset low");
    chk_proc_bound: assert property (wait_r <= PROC_MAX)
        else $error("reset processing overran its limit");
    chk_proc_floor: assert property ($fell(int_reset_out) |->
        wait_r >= CYC_LATER_NOLVD)
        else $error("reset processing shorter than the oscillator wait");
    chk_clk_gate: assert property (int_reset_out |-> !cpu_clk_en_out)
        else $error("cpu clock running during reset");
    chk_hoco_run: assert property (!int_reset_out |-> hoco_sel_out)
        else $error("cpu not on internal oscillator after reset");
    chk_src_reset: assert property ((|src_in) && cpu_clk_en_out |->
        ##[1:3] int_reset_out)
        else $error("reset request did not reset the chip");
    chk_drop_cause: assert property (voltage_drop_interrupt_out |->
        $past(voltage_drop_event_in) &&
        $past(monitor_mode_option_in) == pors_pkg::MODE_INT_RST)
        else $error("drop interrupt without a drop event in mode 2");
    chk_bus_wait: assert property (s_req_start |-> s_one_wait)
        else $error("bus answer not after exactly one wait state");
endmodule : pors_top_monitor

bind pors_top pors_top_monitor #(.CYC_FIRST_LVD(CYC_FIRST_LVD),
    .CYC_LATER_NOLVD(CYC_LATER_NOLVD), .CYC_LVD(CYC_LVD)) pors_top_monitor_i (
    .clk_in(clk_in), .srst_in(srst_in), .cmp_in(cmp_in),
    .ext_reset_n_in(ext_reset_n_in), .src_in(src_in),
    .monitor_mode_option_in(monitor_mode_option_in),
    .voltage_drop_event_in(voltage_drop_event_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out), .int_reset_out(int_reset_out),
    .cpu_clk_en_out(cpu_clk_en_out), .hoco_sel_out(hoco_sel_out),
    .voltage_drop_interrupt_out(voltage_drop_interrupt_out));

//--- sim/pors_supply_model.sv
// Partner model: supply comparators and external reset pin driver
`timescale 1ns/1ps
module pors_supply_model (
    input wire logic clk_in,
    input wire logic [1:0] level_in,
    input wire logic hold_in,
    output pors_pkg::pors_cmp_t cmp_out,
    output logic ext_reset_n_out
);
    // ------------------------------------------------------------
    // Levels: 0 below fall, 1 monitor low, 2 good
    // ------------------------------------------------------------
    initial cmp_out = 4'h5;
    initial ext_reset_n_out = 1'b0;
    // Comparators flip on the clock edge, like a synchronised sensor
    always @(posedge clk_in) begin
        cmp_out.above_rise <= (level_in != 2'h0);
        cmp_out.below_fall <= (level_in == 2'h0);
        cmp_out.mon_above_high <= (level_in == 2'h2);
        cmp_out.mon_below_low <= (level_in != 2'h2);
    end
    // Outside circuit holds the pin low while supply is unusable
    always @(posedge clk_in) begin
        ext_reset_n_out <= !(hold_in || level_in == 2'h0);
    end
endmodule : pors_supply_model

//--- sim/pors_top_test.sv
// Testbench: bus-driven checks of the reset sequencer
`timescale 1ns/1ps
module pors_top_test;
    localparam int C_FL = 20;
    localparam int C_FN = 15;
    localparam int C_LL = 12;
    localparam int C_LN = 8;
    localparam int C_LVD = 5;
    localparam int unsigned CF_POS [4] = '{pors_pkg::CF_ILLMEM,
        pors_pkg::CF_PARITY, pors_pkg::CF_WDT, pors_pkg::CF_SYSREQ};
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [1:0] level = 2'h0;
    logic hold = 1'b1;
    logic [1:0] mode = pors_pkg::MODE_OFF;
    logic drop = 1'b0;
    pors_pkg::pors_rst_src_t src = '0;
    logic [5:0] avs_addr = 6'h00;
    logic avs_rd = 1'b0;
    logic avs_wr = 1'b0;
    logic [31:0] avs_wd = 32'h0;
    pors_pkg::pors_cmp_t cmp;
    logic ext_n, int_reset_out, cpu_clk_en_out, hoco_sel_out;
    logic voltage_drop_interrupt_out, irq_out, avs_waitrequest_out;
    logic [31:0] avs_readdata_out;
    logic [31:0] q;
    logic [7:0] cause = 8'h00;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    always #10 clk_in = ~clk_in;
    pors_supply_model pors_supply_model_i (.clk_in(clk_in), .level_in(level),
        .hold_in(hold), .cmp_out(cmp), .ext_reset_n_out(ext_n));
    pors_top #(.CYC_FIRST_LVD(C_FL), .CYC_FIRST_NOLVD(C_FN),
        .CYC_LATER_LVD(C_LL), .CYC_LATER_NOLVD(C_LN), .CYC_LVD(C_LVD))
    pors_top_i (.clk_in(clk_in), .srst_in(srst_in), .cmp_in(cmp),
        .ext_reset_n_in(ext_n), .src_in(src), .monitor_mode_option_in(mode),
        .voltage_drop_event_in(drop), .avs_address_in(avs_addr),
        .avs_read_in(avs_rd), .avs_write_in(avs_wr), .avs_writedata_in(avs_wd),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .int_reset_out(int_reset_out), .cpu_clk_en_out(cpu_clk_en_out),
        .hoco_sel_out(hoco_sel_out),
        .voltage_drop_interrupt_out(voltage_drop_interrupt_out),
        .irq_out(irq_out));
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_rd <= !wr;
        avs_wr <= wr;
        avs_addr <= a;
        avs_wd <= d;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
        // One wait state: answer on the second edge of the request
        chk(n, 32'h2);
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    // Bounded wait for the internal reset to reach a level
    task automatic wait_lvl(input logic v);
        int n;
        n = 0;
        while (int_reset_out !== v && n < 500) begin
            @(posedge clk_in);
            n++;
        end
        chk(int_reset_out, v);
    endtask : wait_lvl
    // Count cycles until the CPU is released and compare to the window
    task automatic measure(input int exp);
        int n;
        n = 0;
        @(posedge clk_in);
        while (int_reset_out !== 1'b0 && n < 500) begin
            @(posedge clk_in);
            n++;
        end
        check_count++;
        if (n < exp || n > exp + 4) begin
            $display("BAD t=%0t got=%h exp=%h", $time, n, exp);
            err_count++;
        end
        chk(cpu_clk_en_out, 1'b1);
        chk(hoco_sel_out, 1'b1);
    endtask : measure
    task automatic ext_cycle(input int exp);
        @(posedge clk_in);
        hold <= 1'b1;
        repeat (4) @(posedge clk_in);
        hold <= 1'b0;
        measure(exp);
    endtask : ext_cycle
    // Hang guard; the whole run needs a few hundred cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk(int_reset_out, 1'b1);
        level <= 2'h2;
        repeat (4) @(posedge clk_in);
        chk(int_reset_out, 1'b1);
        rd(6'h00, 32'h0);
        bus(1'b1, 6'h3C, 32'hFFFFFFFF);
        rd(6'h3C, 32'h0);
        bus(1'b1, 6'h10, 32'h4);
        ext_cycle(C_FN + 1);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1'b1);
        rd(6'h0C, 32'h4);
        bus(1'b1, 6'h14, 32'h4);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1'b0);
        ext_cycle(C_LN + 1);
        mode <= pors_pkg::MODE_RST;
        ext_cycle(C_LL + C_LVD + 1);
        mode <= pors_pkg::MODE_INT;
        ext_cycle(C_LL + C_LVD + 1);
        mode <= pors_pkg::MODE_RST;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            src <= pors_pkg::pors_rst_src_t'(4'h1 << i);
            @(posedge clk_in);
            src <= '0;
            wait_lvl(1'b1);
            wait_lvl(1'b0);
            cause = cause | (8'h01 << CF_POS[i]);
            rd(6'h00, {24'h0, cause});
        end
        @(posedge clk_in);
        level <= 2'h1;
        repeat (6) @(posedge clk_in);
        chk(int_reset_out, 1'b1);
        level <= 2'h2;
        measure(C_LL + C_LVD + 1);
        rd(6'h00, {24'h0, cause | 8'h01});
        mode <= pors_pkg::MODE_INT_RST;
        bus(1'b1, 6'h04, 32'h0);
        bus(1'b1, 6'h14, 32'h7);
        rd(6'h04, 32'h0);
        bus(1'b1, 6'h10, 32'h2);
        drop <= 1'b1;
        @(posedge clk_in);
        drop <= 1'b0;
        @(posedge clk_in);
        chk(voltage_drop_interrupt_out, 1'b1);
        rd(6'h04, 32'h81);
        chk(irq_out, 1'b1);
        bus(1'b1, 6'h10, 32'h0);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1'b0);
        rd(6'h0C, 32'h2);
        hold <= 1'b1;
        level <= 2'h0;
        repeat (6) @(posedge clk_in);
        chk(int_reset_out, 1'b1);
        level <= 2'h2;
        rd(6'h00, 32'h0);
        mode <= pors_pkg::MODE_RST;
        ext_cycle(C_FL + C_LVD + 1);
        stop_test();
    end
endmodule : pors_top_test
